// ### rtl/lpo_timer.sv
// Countdown timer ticked by the low-power oscillator enable
`timescale 1ns/1ps
`default_nettype none
module lpo_timer #(
   parameter int unsigned WIDTH = sleep_wake_pkg::TIMER_WIDTH
) (
   input  wire logic             clock,
   input  wire logic             sys_rst,
   input  wire logic             clock_enable,
   input  wire logic             lpo_tick,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] load_value,
   output logic                  expired
);
   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic             running;
      logic             expired;
   } timer_state_t;
   timer_state_t state;
   timer_state_t next_state;

   // Load, count down on oscillator ticks, pulse at zero
   always_comb begin
      next_state = state;
      next_state.expired = 1'b0;
      if (load) begin
         next_state.count   = load_value;
         next_state.running = 1'b1;
      end else if (state.running && lpo_tick) begin
         if (state.count <= WIDTH'(sleep_wake_pkg::TIMER_ONE)) begin
            next_state.running = 1'b0;
            next_state.expired = 1'b1;
            next_state.count   = WIDTH'(sleep_wake_pkg::TIMER_ZERO);
         end else begin
            next_state.count = state.count - WIDTH'(sleep_wake_pkg::TIMER_ONE);
         end
      end
   end

   // State register
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state <= '0;
      end else if (clock_enable) begin
         state <= next_state;
      end
   end

   assign expired = state.expired;
endmodule
`default_nettype wire

// ### rtl/sleep_wake_device.sv
// Device end: sleep and wake controller with power-down outputs
// Operation
// - Sleep gates nonessential power and clocks
// - Core stays powered during sleep
// - Asleep, oscillator clocks timer; timer or host wakes
// - Session events wake on timer, then resleep
// - Transports held idle while asleep
// - Host wake accepted anytime during sleep
// - Host-woken session stays awake between events
// - Withdrawn wake request lets device sleep
// - Asserted wake input wakes or keeps awake, except in USB suspend or USB radio-off
// - Deasserted input sleeps once criteria met
// - Both wake pin polarities software selectable
// - Wake input resets to low-active
// - USB mode wake input can disable radio
// - Host wakes when host wake asserted
// - Host may sleep when host wake deasserted
// - Clock request high while reference needed
// - Low reset input resets the block except its timer
// - USB suspend, resume and remote wake supported
// - Radio on only while packets handled
// - Low-power link modes run timed wakes
// - Separate transmit, receive, synthesizer, amplifier power-downs
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_device #(
   parameter int unsigned TW = sleep_wake_pkg::TIMER_WIDTH
) (
   input  wire logic        clock,
   input  wire logic        sys_rst,
   input  wire logic        clock_enable,
   wake_pins_if.device      pins,
   input  wire logic [3:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [15:0] rdata,
   input  wire logic        tx_active,
   input  wire logic        rx_active,
   input  wire logic        link_mode_lowpower,
   output logic             core_power_on,
   output logic             aux_power_on,
   output logic             aux_clock_on,
   output logic             transport_idle,
   output logic             tx_power_down,
   output logic             rx_power_down,
   output logic             synth_power_down,
   output logic             amp_power_down,
   output logic             radio_disabled,
   output logic             asleep
);
   typedef struct packed {
      logic [sleep_wake_pkg::CTL_WIDTH-1:0] ctl;
      logic [TW-1:0]                        sleep_time;
      logic [TW-1:0]                        event_time;
      logic [sleep_wake_pkg::LPO_DIV_WIDTH-1:0] lpo_div;
      logic                                 wake_meta;
      logic                                 wake_sync;
      logic                                 reset_meta;
      logic                                 reset_sync;
      logic                                 host_woke;
      sleep_wake_pkg::power_state_t         pstate;
      logic [15:0]                          rdata;
      logic                                 host_wake_pin;
      logic                                 clk_req;
      logic                                 remote_wake;
      logic                                 aux_on;
      logic                                 tx_pd;
      logic                                 rx_pd;
      logic                                 synth_pd;
      logic                                 amp_pd;
   } dev_state_t;
   dev_state_t s;
   dev_state_t next_s;

   logic lpo_tick;
   logic timer_load;
   logic [TW-1:0] timer_value;
   logic timer_expired;
   logic wake_req;

   // Polarity-adjusted level helper
   function automatic logic active(input logic level, input logic pol);
      active = (pol == sleep_wake_pkg::POL_HIGH_ACTIVE) ? level : ~level;
   endfunction

   // Oscillator tick derived from divider
   assign lpo_tick = (s.lpo_div == sleep_wake_pkg::LPO_DIV_RESET);
   assign wake_req = active(s.wake_sync, s.ctl[sleep_wake_pkg::CTL_DEV_POL]);

   // Sleep and session timer
   lpo_timer #(.WIDTH(TW)) u_timer (
      .clock        (clock),
      .sys_rst      (sys_rst),
      .clock_enable (clock_enable),
      .lpo_tick     (lpo_tick),
      .load         (timer_load),
      .load_value   (timer_value),
      .expired      (timer_expired)
   );

   // Next state, register access and power control
   always_comb begin
      logic sleep_ok;
      logic session;
      logic usb;
      sleep_ok = 1'b0;
      session  = 1'b0;
      usb      = 1'b0;
      next_s = s;
      timer_load  = 1'b0;
      timer_value = s.sleep_time;
      next_s.wake_meta  = pins.device_wake_level;
      next_s.wake_sync  = s.wake_meta;
      next_s.reset_meta = pins.reset_n;
      next_s.reset_sync = s.reset_meta;
      next_s.lpo_div = (s.lpo_div == sleep_wake_pkg::LPO_DIV_RESET) ?
                       sleep_wake_pkg::LPO_DIV_DEFAULT : s.lpo_div - 8'h01;
      session = s.ctl[sleep_wake_pkg::CTL_SESSION_EN] | link_mode_lowpower;
      usb = s.ctl[sleep_wake_pkg::CTL_USB_MODE];
      sleep_ok = s.ctl[sleep_wake_pkg::CTL_SLEEP_EN] & ~wake_req
               & ~s.ctl[sleep_wake_pkg::CTL_TRANSPORT_BUSY]
               & ~tx_active & ~rx_active;
      // Software writes
      if (wr) begin
         case (addr)
            sleep_wake_pkg::ADDR_CONTROL:    next_s.ctl = wdata[sleep_wake_pkg::CTL_WIDTH-1:0];
            sleep_wake_pkg::ADDR_SLEEP_TIME: next_s.sleep_time = wdata[TW-1:0];
            sleep_wake_pkg::ADDR_EVENT_TIME: next_s.event_time = wdata[TW-1:0];
            default: ;
         endcase
      end
      // Software reads, one cycle later
      next_s.rdata = 16'h0000;
      if (rd) begin
         case (addr)
            sleep_wake_pkg::ADDR_CONTROL:    next_s.rdata = 16'(s.ctl);
            sleep_wake_pkg::ADDR_STATUS:     next_s.rdata = {11'h000, s.host_woke,
                                                 wake_req, s.pstate};
            sleep_wake_pkg::ADDR_SLEEP_TIME: next_s.rdata = s.sleep_time;
            sleep_wake_pkg::ADDR_EVENT_TIME: next_s.rdata = s.event_time;
            default:                         next_s.rdata = 16'h0000;
         endcase
      end
      // Power state machine
      case (s.pstate)
         sleep_wake_pkg::ST_AWAKE: begin
            if (usb && s.ctl[sleep_wake_pkg::CTL_RADIO_OFF_EN] && wake_req) begin
               next_s.pstate = sleep_wake_pkg::ST_RADIO_OFF;
            end else if (usb && pins.usb_suspend) begin
               next_s.pstate = sleep_wake_pkg::ST_SUSPEND;
            end else if (sleep_ok && !usb) begin
               next_s.pstate = sleep_wake_pkg::ST_SLEEP;
               next_s.host_woke = 1'b0;
               timer_load  = 1'b1;
               timer_value = s.sleep_time;
            end else if (session && timer_expired) begin
               timer_load  = 1'b1;
               timer_value = s.sleep_time;
            end
         end
         sleep_wake_pkg::ST_SLEEP: begin
            if (wake_req) begin
               next_s.pstate = sleep_wake_pkg::ST_AWAKE;
               next_s.host_woke = 1'b1;
               if (session) begin
                  timer_load  = 1'b1;
                  timer_value = s.sleep_time;
               end
            end else if (timer_expired) begin
               if (session) begin
                  next_s.pstate = sleep_wake_pkg::ST_EVENT;
                  timer_load  = 1'b1;
                  timer_value = s.event_time;
               end else begin
                  next_s.pstate = sleep_wake_pkg::ST_AWAKE;
               end
            end
         end
         sleep_wake_pkg::ST_EVENT: begin
            if (wake_req) begin
               next_s.pstate = sleep_wake_pkg::ST_AWAKE;
               next_s.host_woke = 1'b1;
            end else if (timer_expired) begin
               next_s.pstate = sleep_wake_pkg::ST_SLEEP;
               timer_load  = 1'b1;
               timer_value = s.sleep_time;
            end
         end
         sleep_wake_pkg::ST_RADIO_OFF: begin
            if (!wake_req || !usb || !s.ctl[sleep_wake_pkg::CTL_RADIO_OFF_EN]) begin
               next_s.pstate = sleep_wake_pkg::ST_AWAKE;
            end
         end
         sleep_wake_pkg::ST_SUSPEND: begin
            if (pins.usb_resume || !pins.usb_suspend || !usb) begin
               next_s.pstate = sleep_wake_pkg::ST_AWAKE;
            end else if (s.ctl[sleep_wake_pkg::CTL_REMOTE_WAKE]) begin
               next_s.pstate = sleep_wake_pkg::ST_AWAKE;
            end
         end
         default: next_s.pstate = sleep_wake_pkg::ST_AWAKE;
      endcase
      // Remote wake asserted while suspended and requested
      next_s.remote_wake = (s.pstate == sleep_wake_pkg::ST_SUSPEND)
                           & s.ctl[sleep_wake_pkg::CTL_REMOTE_WAKE];
      // Power gating follows next state
      next_s.aux_on = (next_s.pstate == sleep_wake_pkg::ST_AWAKE) ||
                      (next_s.pstate == sleep_wake_pkg::ST_EVENT);
      next_s.clk_req = next_s.aux_on;
      next_s.tx_pd = ~(next_s.aux_on & tx_active)
                     | (next_s.pstate == sleep_wake_pkg::ST_RADIO_OFF);
      next_s.rx_pd = ~(next_s.aux_on & rx_active)
                     | (next_s.pstate == sleep_wake_pkg::ST_RADIO_OFF);
      next_s.synth_pd = next_s.tx_pd & next_s.rx_pd;
      next_s.amp_pd   = next_s.tx_pd;
      next_s.host_wake_pin = s.ctl[sleep_wake_pkg::CTL_HOST_WAKE] ~^
                             s.ctl[sleep_wake_pkg::CTL_HOST_POL];
   end

   // State register; pin reset or system reset loads reset values
   always_ff @(posedge clock) begin
      if (sys_rst || !s.reset_sync) begin
         s <= '0;
         s.ctl        <= sleep_wake_pkg::CTL_RESET;
         s.sleep_time <= sleep_wake_pkg::SLEEP_TIME_RESET;
         s.event_time <= sleep_wake_pkg::EVENT_TIME_RESET;
         s.reset_meta <= 1'b1;
         s.reset_sync <= 1'b1;
         s.wake_meta  <= 1'b1;
         s.wake_sync  <= 1'b1;
         s.aux_on     <= 1'b1;
         s.clk_req    <= 1'b1;
         s.tx_pd      <= 1'b1;
         s.rx_pd      <= 1'b1;
         s.synth_pd   <= 1'b1;
         s.amp_pd     <= 1'b1;
         s.pstate     <= sleep_wake_pkg::ST_AWAKE;
      end else if (clock_enable) begin
         s <= next_s;
      end
   end

   // Outputs from state flip-flops; core power tied on
   assign core_power_on          = 1'b1;
   assign aux_power_on           = s.aux_on;
   assign aux_clock_on           = s.aux_on;
   assign transport_idle         = ~s.aux_on;
   assign tx_power_down          = s.tx_pd;
   assign rx_power_down          = s.rx_pd;
   assign synth_power_down       = s.synth_pd;
   assign amp_power_down         = s.amp_pd;
   assign radio_disabled         = (s.pstate == sleep_wake_pkg::ST_RADIO_OFF);
   assign asleep                 = ~s.aux_on;
   assign rdata                  = s.rdata;
   assign pins.host_wake_request = s.host_wake_pin;
   assign pins.ref_clock_request = s.clk_req;
   assign pins.usb_remote_wake   = s.remote_wake;
endmodule
`default_nettype wire

// ### rtl/sleep_wake_host.sv
// Host end: drives wake and reset pins, samples device wake outputs
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_host (
   input  wire logic        clock,
   input  wire logic        sys_rst,
   input  wire logic        clock_enable,
   wake_pins_if.host        pins,
   input  wire logic [1:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [15:0] rdata,
   input  wire logic        suspend_req,
   input  wire logic        resume_req,
   output logic             host_stay_awake
);
   typedef struct packed {
      logic [sleep_wake_pkg::HCTL_WIDTH-1:0] ctl;
      logic [15:0]                           rdata;
      logic                                  dev_wake_pin;
      logic                                  reset_pin;
      logic                                  suspend;
      logic                                  resume;
      logic                                  stay_awake;
   } host_state_t;
   host_state_t s;
   host_state_t next_s;

   // Pin level for a wanted state under a polarity
   function automatic logic drive(input logic want, input logic pol);
      drive = (pol == sleep_wake_pkg::POL_HIGH_ACTIVE) ? want : ~want;
   endfunction

   // Commands, status reads and pin levels
   always_comb begin
      next_s = s;
      if (wr && addr == sleep_wake_pkg::HADDR_CONTROL) begin
         next_s.ctl = wdata[sleep_wake_pkg::HCTL_WIDTH-1:0];
      end
      next_s.rdata = 16'h0000;
      if (rd) begin
         case (addr)
            sleep_wake_pkg::HADDR_CONTROL: next_s.rdata = 16'(s.ctl);
            sleep_wake_pkg::HADDR_STATUS:  next_s.rdata = {13'h0000, pins.usb_remote_wake,
                                               pins.ref_clock_request, s.stay_awake};
            default:                       next_s.rdata = 16'h0000;
         endcase
      end
      next_s.dev_wake_pin = drive(s.ctl[sleep_wake_pkg::HCTL_WAKE],
                                  s.ctl[sleep_wake_pkg::HCTL_DEV_POL]);
      next_s.reset_pin    = s.ctl[sleep_wake_pkg::HCTL_RESET_N];
      next_s.suspend      = (s.suspend | suspend_req) & ~resume_req;
      next_s.resume       = resume_req;
      next_s.stay_awake   = ~(pins.host_wake_request ^
                              s.ctl[sleep_wake_pkg::HCTL_HOST_POL]);
   end

   // State register
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         s <= '0;
         s.ctl       <= sleep_wake_pkg::HCTL_RESET;
         s.reset_pin <= 1'b1;
         s.dev_wake_pin <= ~sleep_wake_pkg::DEV_WAKE_POL_RESET; // Idle level, no false wake
      end else if (clock_enable) begin
         s <= next_s;
      end
   end

   assign pins.device_wake_level = s.dev_wake_pin;
   assign pins.reset_n           = s.reset_pin;
   assign pins.usb_suspend       = s.suspend;
   assign pins.usb_resume        = s.resume;
   assign rdata                  = s.rdata;
   assign host_stay_awake        = s.stay_awake;
endmodule
`default_nettype wire

// ### rtl/sleep_wake_pkg.sv
// Shared constants and types for the sleep and wake controller pair
package sleep_wake_pkg;
   // Wake pin polarity encodings
   localparam logic POL_LOW_ACTIVE  = 1'b0;
   localparam logic POL_HIGH_ACTIVE = 1'b1;
   localparam logic DEV_WAKE_POL_RESET  = POL_LOW_ACTIVE;
   localparam logic HOST_WAKE_POL_RESET = POL_HIGH_ACTIVE;
   // Timer widths and defaults
   localparam int unsigned TIMER_WIDTH       = 16;
   localparam logic [15:0] SLEEP_TIME_RESET  = 16'h0040;
   localparam logic [15:0] EVENT_TIME_RESET  = 16'h0008;
   localparam logic [15:0] TIMER_ONE         = 16'h0001;
   localparam logic [15:0] TIMER_ZERO        = 16'h0000;
   // Low-power oscillator divider (reload value, one less than system clock ticks per oscillator tick)
   localparam int unsigned LPO_DIV_WIDTH     = 8;
   localparam logic [7:0]  LPO_DIV_RESET     = 8'h00;
   localparam logic [7:0]  LPO_DIV_DEFAULT   = 8'h04;
   // Software port offsets
   localparam logic [3:0] ADDR_CONTROL     = 4'h0;
   localparam logic [3:0] ADDR_STATUS      = 4'h1;
   localparam logic [3:0] ADDR_SLEEP_TIME  = 4'h2;
   localparam logic [3:0] ADDR_EVENT_TIME  = 4'h3;
   // Control register fields
   localparam int unsigned CTL_SLEEP_EN     = 0;
   localparam int unsigned CTL_SESSION_EN   = 1;
   localparam int unsigned CTL_DEV_POL      = 2;
   localparam int unsigned CTL_HOST_POL     = 3;
   localparam int unsigned CTL_RADIO_OFF_EN = 4;
   localparam int unsigned CTL_USB_MODE     = 5;
   localparam int unsigned CTL_HOST_WAKE    = 6;
   localparam int unsigned CTL_REMOTE_WAKE  = 7;
   localparam int unsigned CTL_TRANSPORT_BUSY = 8;
   localparam int unsigned CTL_WIDTH        = 9;
   localparam logic [8:0]  CTL_RESET        = 9'h008;
   // Host controller port offsets
   localparam logic [1:0] HADDR_CONTROL = 2'h0;
   localparam logic [1:0] HADDR_STATUS  = 2'h1;
   // Host control fields
   localparam int unsigned HCTL_WAKE     = 0;
   localparam int unsigned HCTL_DEV_POL  = 1;
   localparam int unsigned HCTL_HOST_POL = 2;
   localparam int unsigned HCTL_RESET_N  = 3;
   localparam int unsigned HCTL_WIDTH    = 4;
   localparam logic [3:0]  HCTL_RESET    = 4'hC;
   // Device power states
   typedef enum logic [2:0] {
      ST_AWAKE,
      ST_SLEEP,
      ST_EVENT,
      ST_RADIO_OFF,
      ST_SUSPEND
   } power_state_t;
endpackage

// ### rtl/wake_pins_if.sv
// Wake, clock request and reset pins between host and device
`timescale 1ns/1ps
`default_nettype none
interface wake_pins_if;
   logic device_wake_level;   // Host drives device wake pin
   logic host_wake_request;   // Device drives host wake pin
   logic ref_clock_request;   // Device asks for reference clock
   logic reset_n;             // Host drives chip reset, active low
   logic usb_resume;          // Host resume signalling
   logic usb_suspend;         // Host suspend signalling
   logic usb_remote_wake;     // Device remote wake-up signalling
   modport device (input device_wake_level, reset_n, usb_resume, usb_suspend,
                   output host_wake_request, ref_clock_request, usb_remote_wake);
   modport host (output device_wake_level, reset_n, usb_resume, usb_suspend,
                 input host_wake_request, ref_clock_request, usb_remote_wake);
endinterface
`default_nettype wire

// ### test/host_sleep_wake_controller_tb_top.sv
// Testbench joining the device and host ends over the wake pins
`timescale 1ns/1ps
`default_nettype none
module host_sleep_wake_controller_tb_top;
   logic        clock, sys_rst, cen, radio_busy, d_wr, d_rd, h_wr, h_rd;
   logic [3:0]  d_addr;
   logic [1:0]  h_addr;
   logic [15:0] d_wdata, h_wdata, d_rdata, h_rdata;
   logic        core_power_on, aux_power_on, aux_clock_on, transport_idle;
   logic        tx_power_down, radio_disabled, asleep, host_stay_awake;
   logic        rx_power_down, synth_power_down, amp_power_down, lowpower, susp, resm, rw_seen;
   int          miscompares, num_checks, cycles;
   wake_pins_if wake_pins_if_inst ();
   sleep_wake_device #(.TW(16)) sleep_wake_device_inst (.clock, .sys_rst, .clock_enable(cen),
      .pins(wake_pins_if_inst.device), .addr(d_addr), .wdata(d_wdata), .wr(d_wr), .rd(d_rd),
      .rdata(d_rdata), .tx_active(radio_busy), .rx_active(radio_busy), .link_mode_lowpower(lowpower),
      .core_power_on, .aux_power_on, .aux_clock_on, .transport_idle, .tx_power_down,
      .rx_power_down, .synth_power_down, .amp_power_down, .radio_disabled, .asleep);
   sleep_wake_host sleep_wake_host_inst (.clock, .sys_rst, .clock_enable(cen),
      .pins(wake_pins_if_inst.host), .addr(h_addr), .wdata(h_wdata), .wr(h_wr), .rd(h_rd),
      .rdata(h_rdata), .suspend_req(susp), .resume_req(resm), .host_stay_awake);
   sleep_wake_sva sleep_wake_sva_inst (.clock, .sys_rst,
      .device_wake_level(wake_pins_if_inst.device_wake_level),
      .reset_n(wake_pins_if_inst.reset_n), .ref_clock_request(wake_pins_if_inst.ref_clock_request),
      .core_power_on, .aux_power_on, .aux_clock_on, .transport_idle, .tx_power_down,
      .radio_disabled, .asleep, .rx_pd(rx_power_down), .synth_pd(synth_power_down),
      .amp_pd(amp_power_down));
   // ****************
   // Tasks
   // ****************
   // Compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string w);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t %s got %h exp %h", $time, w, got, exp);
      end
   endtask
   // One port access; a read compares masked data
   task automatic acc(input bit hs, input bit wr, input logic [3:0] a, input logic [15:0] d,
                      input logic [15:0] m, input string w);
      @(posedge clock);
      d_addr <= a;
      h_addr <= a[1:0];
      d_wdata <= d;
      h_wdata <= d;
      {d_wr, d_rd} <= hs ? 2'b00 : {wr, !wr};
      {h_wr, h_rd} <= hs ? {wr, !wr} : 2'b00;
      @(posedge clock);
      {d_wr, d_rd, h_wr, h_rd} <= 4'h0;
      #1;
      if (!wr) chk((hs ? h_rdata : d_rdata) & m, d, w);
   endtask
   // Bounded wait for the sleep output
   task automatic await(input logic want, input int lim);
      int n;
      n = 0;
      while (asleep !== want && n < lim) begin
         @(posedge clock);
         #1;
         n++;
      end
      chk({15'h0, asleep}, {15'h0, want}, "sleep output");
   endtask
   // Sleep output must not change for a span
   task automatic hold(input logic want, input int len);
      int bad;
      bad = 0;
      repeat (len) begin
         @(posedge clock);
         #1;
         if (asleep !== want) bad++;
      end
      chk(bad[15:0], 16'h0, "sleep output held");
   endtask
   // Counts and verdict
   task automatic summarize();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ****************
   // Clock, timeout, tests
   // ****************
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // Hang limit
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         summarize();
      end
   end
   // Remote wake seen on the pin since reset
   always @(posedge clock) begin
      rw_seen <= sys_rst ? 1'b0 : (rw_seen | wake_pins_if_inst.usb_remote_wake);
   end
   initial begin
      {sys_rst, cen} = 2'b11;
      {radio_busy, d_wr, d_rd, h_wr, h_rd, d_addr, h_addr, d_wdata, h_wdata} = '0;
      {lowpower, susp, resm} = '0;
      repeat (6) @(posedge clock);
      sys_rst <= 1'b0;
      acc(0, 0, 4'h0, {13'h0, sleep_wake_pkg::DEV_WAKE_POL_RESET, 2'h0}, 16'h0004, "pol");
      acc(0, 0, 4'h2, sleep_wake_pkg::SLEEP_TIME_RESET, 16'hFFFF, "sleep time");
      acc(0, 0, 4'hF, 16'h0, 16'hFFFF, "unmapped read");
      acc(1, 0, 4'h1, 16'h0002, 16'h0007, "host status");
      $display("test reset_values done");
      radio_busy <= 1'b1;
      acc(0, 1, 4'h0, 16'h0005, 16'h0, "");
      acc(1, 1, 4'h0, 16'h000A, 16'h0, "");
      hold(1'b0, 40);
      chk({15'h0, tx_power_down}, 16'h0, "tx powered");
      @(posedge clock);
      radio_busy <= 1'b0;
      await(1'b1, 60);
      $display("test sleep_criteria done");
      for (int p = 0; p < 2; p++) begin
         acc(0, 1, 4'h0, 16'h0001 | (p << 2) | (p << 3), 16'h0, "");
         acc(1, 1, 4'h0, 16'h0008 | (p << 1) | (p << 2), 16'h0, "");
         await(1'b1, 60);
         acc(1, 1, 4'h0, 16'h0009 | (p << 1) | (p << 2), 16'h0, "");
         await(1'b0, 20);
         hold(1'b0, 100);
         acc(0, 1, 4'h0, 16'h0041 | (p << 2) | (p << 3), 16'h0, "");
         repeat (6) @(posedge clock);
         chk({15'h0, host_stay_awake}, 16'h1, "host wake on");
         acc(0, 1, 4'h0, 16'h0001 | (p << 2) | (p << 3), 16'h0, "");
         repeat (6) @(posedge clock);
         chk({15'h0, host_stay_awake}, 16'h0, "host wake off");
         acc(1, 1, 4'h0, 16'h0008 | (p << 1) | (p << 2), 16'h0, "");
         await(1'b1, 60);
      end
      $display("test polarity_wake done");
      acc(1, 1, 4'h0, 16'h000B, 16'h0, "");
      acc(0, 1, 4'h2, 16'h0004, 16'h0, "");
      acc(0, 1, 4'h3, 16'h0002, 16'h0, "");
      acc(0, 1, 4'h0, 16'h0007, 16'h0, "");
      acc(1, 1, 4'h0, 16'h000A, 16'h0, "");
      await(1'b1, 30);
      await(1'b0, 200);
      await(1'b1, 200);
      acc(1, 1, 4'h0, 16'h000B, 16'h0, "");
      await(1'b0, 30);
      hold(1'b0, 200);
      acc(1, 1, 4'h0, 16'h000A, 16'h0, "");
      await(1'b1, 30);
      lowpower <= 1'b1;
      acc(0, 1, 4'h0, 16'h0005, 16'h0, "");
      await(1'b0, 200);
      acc(0, 0, 4'h1, {13'h0, sleep_wake_pkg::ST_EVENT}, 16'h0007, "event state");
      await(1'b1, 200);
      lowpower <= 1'b0;
      $display("test session done");
      acc(1, 1, 4'h0, 16'h000B, 16'h0, "");
      acc(0, 1, 4'h0, 16'h0034, 16'h0, "");
      repeat (6) @(posedge clock);
      chk({15'h0, radio_disabled}, 16'h1, "radio off");
      acc(1, 1, 4'h0, 16'h000A, 16'h0, "");
      repeat (6) @(posedge clock);
      chk({15'h0, radio_disabled}, 16'h0, "radio back on");
      susp <= 1'b1;
      @(posedge clock);
      susp <= 1'b0;
      await(1'b1, 10);
      acc(0, 1, 4'h0, 16'h00A4, 16'h0, "");
      repeat (4) @(posedge clock);
      chk({15'h0, rw_seen}, 16'h1, "remote wake");
      resm <= 1'b1;
      @(posedge clock);
      resm <= 1'b0;
      hold(1'b0, 20);
      $display("test usb done");
      acc(1, 1, 4'h0, 16'h0002, 16'h0, "");
      repeat (8) @(posedge clock);
      acc(1, 1, 4'h0, 16'h000A, 16'h0, "");
      repeat (4) @(posedge clock);
      acc(0, 0, 4'h2, sleep_wake_pkg::SLEEP_TIME_RESET, 16'hFFFF, "pin reset");
      $display("test pin_reset done");
      summarize();
   end
endmodule
`default_nettype wire

// ### test/sleep_wake_sva.sv
// Checker on the wake pins and power outputs of the pair
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_sva (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic device_wake_level,
   input wire logic reset_n,
   input wire logic ref_clock_request,
   input wire logic core_power_on,
   input wire logic aux_power_on,
   input wire logic aux_clock_on,
   input wire logic transport_idle,
   input wire logic tx_power_down,
   input wire logic rx_pd,
   input wire logic synth_pd,
   input wire logic amp_pd,
   input wire logic radio_disabled,
   input wire logic asleep
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   // Pin reset held low for three edges
   sequence pin_reset_s;
      (!reset_n)[*3];
   endsequence
   AST_CORE_ON: assert property (core_power_on)
      else $error("core power dropped");
   AST_GATED: assert property (asleep |-> !aux_power_on && !aux_clock_on)
      else $error("aux power or clock on while asleep");
   AST_IDLE: assert property (asleep |-> transport_idle)
      else $error("transport busy while asleep");
   AST_CLK_REQ: assert property (aux_clock_on |-> ref_clock_request)
      else $error("clock running without reference request");
   AST_RST_VALS: assert property ($fell(sys_rst) |-> aux_power_on && ref_clock_request)
      else $error("wrong state after reset");
   AST_PIN_RST: assert property (pin_reset_s |-> ##[1:4] (aux_power_on && !asleep))
      else $error("pin reset did not reset");
   AST_SYNC: assert property ($changed(device_wake_level) && asleep |=> asleep)
      else $error("wake pin acted without synchroniser");
   AST_RF_OFF: assert property (asleep |-> tx_power_down)
      else $error("transmit path powered while asleep");
   AST_RF_ALL: assert property (asleep |-> rx_pd && synth_pd && amp_pd)
      else $error("receive, synthesizer or amplifier powered while asleep");
   AST_RADIO: assert property (radio_disabled |-> tx_power_down)
      else $error("transmit path powered with radio off");
endmodule
`default_nettype wire
